// ### rtl/bmp_ctrl.sv
// The address map and register access over AXI4-Lite were left to the implementer.
module bmp_ctrl #(
  parameter int ENTER_CYC  = bmp_pkg::ENTER_CYC,
  parameter int OVLD_CYC   = bmp_pkg::OVLD_CYC,
  parameter int ZC_OVP_CYC = bmp_pkg::ZC_OVP_CYC,
  parameter int MAX_ON_CYC = bmp_pkg::MAX_ON_CYC
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire bmp_pkg::bmp_flags_s flags,
  output logic                    gate_on,
  output logic                    bias_en,
  output logic                    startup_en,
  output logic                    burst_ilim,
  output logic                    soft_start,
  output logic                    burst_mode,
  output logic                    latched_off,
  output logic [2:0]              valley_cnt,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  typedef struct packed {
    bmp_pkg::bmp_flags_s s1;
    bmp_pkg::bmp_flags_s s2;
    bmp_pkg::bmp_st_e    st;
    logic                paused;
    logic                gate;
    logic                bias;
    logic                startup;
    logic                ilim;
    logic                ss;
    logic [2:0]          vdc;
    logic                bmode;
    logic                lat;
    bmp_pkg::bmp_cnt_t   eb;
    bmp_pkg::bmp_cnt_t   ovp;
    bmp_pkg::bmp_cnt_t   ol;
    bmp_pkg::bmp_cnt_t   zco;
    bmp_pkg::bmp_cnt_t   sw;
    bmp_pkg::bmp_cnt_t   on;
    bmp_pkg::bmp_cnt_t   bt;
    logic                burst_en;
    logic                awrdy;
    logic                wrdy;
    logic                bvalid;
    logic [1:0]          bresp;
    logic [7:0]          awaddr;
    logic                wbit;
    logic                wstb;
    logic                arrdy;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
  } bmp_state_s;

  localparam bmp_pkg::bmp_cnt_t ENTER_C = bmp_pkg::bmp_cnt_t'(ENTER_CYC);
  localparam bmp_pkg::bmp_cnt_t OVLD_C  = bmp_pkg::bmp_cnt_t'(OVLD_CYC);
  localparam bmp_pkg::bmp_cnt_t ZCO_C   = bmp_pkg::bmp_cnt_t'(ZC_OVP_CYC);
  localparam bmp_pkg::bmp_cnt_t MAXON_C = bmp_pkg::bmp_cnt_t'(MAX_ON_CYC);
  localparam bmp_pkg::bmp_cnt_t OVQ_C   = bmp_pkg::bmp_cnt_t'(bmp_pkg::VCC_OV_CYC);
  localparam bmp_pkg::bmp_cnt_t SW_C    = bmp_pkg::bmp_cnt_t'(bmp_pkg::SW_CYC);
  localparam bmp_pkg::bmp_cnt_t PER_C   = bmp_pkg::bmp_cnt_t'(bmp_pkg::BURST_PER_CYC);
  localparam bmp_pkg::bmp_cnt_t BON_C   = bmp_pkg::bmp_cnt_t'(bmp_pkg::BURST_ON_CYC);

  bmp_state_s q;
  bmp_state_s d;

  // Saturating count of how long a condition has held; zero once it drops
  function automatic bmp_pkg::bmp_cnt_t qual(bmp_pkg::bmp_cnt_t c, logic cond, bmp_pkg::bmp_cnt_t lim);
    if (!cond) begin
      return '0;
    end
    return (c >= lim) ? lim : c + 1'b1;
  endfunction : qual

  always_comb begin
    bmp_pkg::bmp_flags_s f;
    logic                run;
    logic                op;
    logic                lo;
    logic                ar;
    logic [31:0]         r;
    f   = q.s2;
    run = (q.st == bmp_pkg::ST_RUN);
    op  = run || (q.st == bmp_pkg::ST_BURST);
    r   = '0;
    ar  = run && (f.otp || q.ovp == OVQ_C || q.ol == OVLD_C);
    lo  = op && (q.zco == ZCO_C || q.sw == SW_C);
    d   = q;
    d.s1 = flags;
    d.s2 = q.s1;
    d.ss = 1'b0;
    d.on  = qual(q.on, q.gate, MAXON_C);
    d.ovp = qual(q.ovp, f.vcc_ov && run, OVQ_C);
    d.ol  = qual(q.ol, f.fb_leave && run, OVLD_C);
    d.zco = qual(q.zco, f.zc_ovp && !q.gate && op, ZCO_C);
    d.sw  = qual(q.sw, f.cs_sw && q.gate && run, SW_C);
    d.eb  = qual(q.eb, f.fb_enter && q.vdc == bmp_pkg::VDC_BURST && q.burst_en && run, ENTER_C);
    case (q.st)
      bmp_pkg::ST_CHARGE: begin
        d.gate    = 1'b0;
        d.bias    = 1'b0;
        d.startup = 1'b1;
        if (f.vcc_on) begin
          d.st      = bmp_pkg::ST_RUN;
          d.startup = 1'b0;
          d.bias    = 1'b1;
          d.ss      = 1'b1;
        end
      end
      bmp_pkg::ST_RUN: begin
        if (!q.gate && f.norm_on) begin
          d.gate = 1'b1;
        end
        if (q.gate && (f.cs_pk || q.on == MAXON_C)) begin
          d.gate = 1'b0;
        end
        if (f.vdc_up && !f.vdc_dn && q.vdc != bmp_pkg::VDC_MAX) begin
          d.vdc = q.vdc + 3'h1;
        end else if (f.vdc_dn && !f.vdc_up && q.vdc != 3'h0) begin
          d.vdc = q.vdc - 3'h1;
        end
        if (q.eb == ENTER_C) begin
          d.st     = bmp_pkg::ST_BURST;
          d.gate   = 1'b0;
          d.paused = 1'b1;
          d.bias   = 1'b0;
          d.bt     = '0;
          d.ilim   = 1'b1;
        end
      end
      bmp_pkg::ST_BURST: begin
        d.bt = (q.bt == PER_C - 1'b1) ? '0 : q.bt + 1'b1;
        if (q.paused) begin
          if (f.fb_bon) begin
            d.paused = 1'b0;
            d.bias   = 1'b1;
          end
        end else if (f.fb_boff) begin
          d.paused = 1'b1;
          d.bias   = 1'b0;
          d.gate   = 1'b0;
        end else if (!q.gate && q.bt == PER_C - 1'b1) begin
          d.gate = 1'b1;
        end else if (q.gate && (f.cs_bpk || q.bt >= BON_C - 1'b1 || q.on == MAXON_C)) begin
          d.gate = 1'b0;
        end
        if (f.fb_leave) begin
          d.st     = bmp_pkg::ST_RUN;
          d.gate   = 1'b0;
          d.paused = 1'b0;
          d.bias   = 1'b1;
          d.ilim   = 1'b0;
          d.vdc    = bmp_pkg::VDC_LEAVE;
        end
      end
      bmp_pkg::ST_RESTART: begin
        d.gate    = 1'b0;
        d.bias    = 1'b0;
        d.startup = 1'b0;
        if (f.vcc_off) begin
          d.st = bmp_pkg::ST_CHARGE;
        end
      end
      bmp_pkg::ST_LATCH: begin
        d.gate = 1'b0;
        d.bias = 1'b0;
        if (f.vcc_off) begin
          d.startup = 1'b1;
        end else if (f.vcc_on) begin
          d.startup = 1'b0;
        end
        if (f.vcc_pd) begin
          d.st      = bmp_pkg::ST_CHARGE;
          d.startup = 1'b1;
        end
      end
      default: begin
        d.st = bmp_pkg::ST_CHARGE;
      end
    endcase
    if (lo) begin
      d.st = bmp_pkg::ST_LATCH;
    end else if (op && f.vcc_off) begin
      d.st      = bmp_pkg::ST_CHARGE;
      d.startup = 1'b1;
    end else if (ar) begin
      d.st = bmp_pkg::ST_RESTART;
    end
    if (op && (lo || f.vcc_off || ar)) begin
      d.gate   = 1'b0;
      d.bias   = 1'b0;
      d.ilim   = 1'b0;
      d.paused = 1'b0;
      d.vdc    = '0;
    end
    // Mode pins kept in flops so they carry no decode glitches
    d.bmode = (d.st == bmp_pkg::ST_BURST);
    d.lat   = (d.st == bmp_pkg::ST_LATCH);
    // Register bus: write address and data in either order
    if (s_axi_awvalid && q.awrdy) begin
      d.awrdy  = 1'b0;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wrdy) begin
      d.wrdy = 1'b0;
      d.wbit = s_axi_wdata[bmp_pkg::CTRL_BURST_EN_BIT];
      d.wstb = s_axi_wstrb[0];
    end
    if (!q.awrdy && !q.wrdy && !q.bvalid) begin
      d.bvalid = 1'b1;
      d.bresp  = bmp_pkg::RESP_OKAY;
      if (q.awaddr[7:2] == bmp_pkg::CTRL_OFF[7:2]) begin
        if (q.wstb) begin
          d.burst_en = q.wbit;
        end
      end else if (q.awaddr[7:2] != bmp_pkg::STAT_OFF[7:2]) begin
        d.bresp = bmp_pkg::RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.awrdy  = 1'b1;
      d.wrdy   = 1'b1;
    end
    r[bmp_pkg::STAT_ST_LSB +: 3]   = q.st;
    r[bmp_pkg::STAT_PAUSE_BIT]     = q.paused;
    r[bmp_pkg::STAT_GATE_BIT]      = q.gate;
    r[bmp_pkg::STAT_BIAS_BIT]      = q.bias;
    r[bmp_pkg::STAT_START_BIT]     = q.startup;
    r[bmp_pkg::STAT_ILIM_BIT]      = q.ilim;
    r[bmp_pkg::STAT_VDC_LSB +: 3]  = q.vdc;
    if (s_axi_arvalid && q.arrdy) begin
      d.arrdy  = 1'b0;
      d.rvalid = 1'b1;
      d.rresp  = bmp_pkg::RESP_OKAY;
      d.rdata  = '0;
      if (s_axi_araddr[7:2] == bmp_pkg::CTRL_OFF[7:2]) begin
        d.rdata[bmp_pkg::CTRL_BURST_EN_BIT] = q.burst_en;
      end else if (s_axi_araddr[7:2] == bmp_pkg::STAT_OFF[7:2]) begin
        d.rdata = r;
      end else begin
        d.rresp = bmp_pkg::RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arrdy  = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.st       <= bmp_pkg::ST_CHARGE;
      q.startup  <= 1'b1;
      q.burst_en <= bmp_pkg::CTRL_BURST_EN_RST;
      q.awrdy    <= 1'b1;
      q.wrdy     <= 1'b1;
      q.arrdy    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign gate_on       = q.gate;
  assign bias_en       = q.bias;
  assign startup_en    = q.startup;
  assign burst_ilim    = q.ilim;
  assign soft_start    = q.ss;
  assign burst_mode    = q.bmode;
  assign latched_off   = q.lat;
  assign valley_cnt    = q.vdc;
  assign s_axi_awready = q.awrdy;
  assign s_axi_wready  = q.wrdy;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arrdy;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_burst_run;
    q.st == bmp_pkg::ST_BURST && !q.paused;
  endsequence

  sequence s_pause_done;
    !q.bias && !q.gate && q.paused;
  endsequence

  a_max_on_cut: assert property (q.gate && q.on == MAXON_C |=> !q.gate)
    else $error("gate held past max on-time");
  a_on_bound: assert property (q.gate |-> q.on <= MAXON_C)
    else $error("on-time count past limit");
  a_burst_duty: assert property (s_burst_run ##0 q.gate |-> q.bt < BON_C)
    else $error("burst duty above half");
  a_burst_peak: assert property (s_burst_run ##0 q.gate && q.s2.cs_bpk && !q.s2.fb_leave |=> !q.gate)
    else $error("burst peak did not end pulse");
  a_burst_pause: assert property (s_burst_run ##0 q.s2.fb_boff && !q.s2.fb_leave |=> s_pause_done)
    else $error("burst-off did not pause");
  a_burst_entry: assert property ($rose(q.st == bmp_pkg::ST_BURST) |-> $past(q.eb) == ENTER_C)
    else $error("burst entered without blanking");
  a_leave_preset: assert property (q.st == bmp_pkg::ST_BURST ##1 q.st == bmp_pkg::ST_RUN
                                   |-> q.vdc == bmp_pkg::VDC_LEAVE && !q.ilim)
    else $error("counter not preset on leaving burst");
  a_latch_hold: assert property (q.st == bmp_pkg::ST_LATCH && !q.s2.vcc_pd |=> q.st == bmp_pkg::ST_LATCH)
    else $error("latch cleared without power-down");
  a_sw_latch: assert property (q.st == bmp_pkg::ST_RUN && q.sw == SW_C |=> q.st == bmp_pkg::ST_LATCH)
    else $error("short winding did not latch");
  a_off_states: assert property (q.st inside {bmp_pkg::ST_CHARGE, bmp_pkg::ST_RESTART, bmp_pkg::ST_LATCH}
                                 |-> !q.gate)
    else $error("gate high while held off");
  a_sync_path: assert property ($rose(q.s1.otp) |=> q.s2.otp)
    else $error("flag sync stage broken");
  a_latch_prio: assert property ((q.st == bmp_pkg::ST_RUN || q.st == bmp_pkg::ST_BURST)
                                 && (q.zco == ZCO_C || q.sw == SW_C) |=> q.st == bmp_pkg::ST_LATCH)
    else $error("latch did not win over restart");

endmodule : bmp_ctrl

// ### rtl/bmp_pkg.sv
package bmp_pkg;

  // Timing base
  localparam int CLK_HZ        = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;

  // Times in their own units
  localparam int BURST_RATE_HZ   = 52_000;
  localparam int BURST_DUTY_PCT  = 50;
  localparam int ENTER_BLANK_MS  = 24;
  localparam int OVLD_BLANK_MS   = 30;
  localparam int VCC_OV_QUAL_US  = 10;
  localparam int ZC_OVP_BLANK_US = 100;
  localparam int SW_BLANK_NS     = 190;
  localparam int MAX_ON_US       = 30;

  // Cycle counts; least times round up, longest round down
  localparam int BURST_PER_CYC  = CLK_HZ / BURST_RATE_HZ;
  localparam int BURST_ON_CYC   = BURST_PER_CYC * BURST_DUTY_PCT / 100;
  localparam int ENTER_CYC      = ENTER_BLANK_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int OVLD_CYC       = OVLD_BLANK_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int VCC_OV_CYC     = (VCC_OV_QUAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ZC_OVP_CYC     = (ZC_OVP_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_CYC         = (SW_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_ON_CYC     = MAX_ON_US * 1000 / CLK_PERIOD_NS;

  // Valley up/down counter
  localparam logic [2:0] VDC_BURST = 3'h7;
  localparam logic [2:0] VDC_LEAVE = 3'h1;
  localparam logic [2:0] VDC_MAX   = 3'h7;

  // Register map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam int         CTRL_BURST_EN_BIT = 0;
  localparam logic       CTRL_BURST_EN_RST = 1'b1;
  localparam int         STAT_ST_LSB    = 0;
  localparam int         STAT_PAUSE_BIT = 4;
  localparam int         STAT_GATE_BIT  = 5;
  localparam int         STAT_BIAS_BIT  = 6;
  localparam int         STAT_START_BIT = 7;
  localparam int         STAT_ILIM_BIT  = 8;
  localparam int         STAT_VDC_LSB   = 12;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [23:0] bmp_cnt_t;

  typedef enum logic [2:0] {ST_CHARGE, ST_RUN, ST_BURST, ST_RESTART, ST_LATCH} bmp_st_e;

  // Comparator and valley-logic flags
  typedef struct packed {
    logic fb_enter;
    logic fb_bon;
    logic fb_boff;
    logic fb_leave;
    logic cs_bpk;
    logic cs_pk;
    logic cs_sw;
    logic zc_ovp;
    logic vcc_off;
    logic vcc_on;
    logic vcc_pd;
    logic vcc_ov;
    logic otp;
    logic norm_on;
    logic vdc_up;
    logic vdc_dn;
  } bmp_flags_s;

endpackage : bmp_pkg

// ### testbench/bmp_plant.sv
module bmp_plant (
  input  wire logic          aclk,
  input  wire logic          gate_on,
  input  wire logic [11:0]   fb_lvl,
  input  wire logic [11:0]   vcc_lvl,
  input  wire logic [11:0]   bpk_at,
  input  wire logic [5:0]    misc,
  output bmp_pkg::bmp_flags_s flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // Levels in 10 mV steps; power-down level is not given, so a plain default
  parameter logic [11:0] PD_LVL = 12'h258;
  logic [11:0] ramp_q;
  // Sense ramp grows only while the switch conducts, so peak flags never show in off-time
  always_ff @(posedge aclk) ramp_q <= gate_on ? ramp_q + 12'h001 : 12'h000;
  always_comb begin
    flags.fb_enter = fb_lvl < 12'h07d;
    flags.fb_bon   = fb_lvl > 12'h168;
    flags.fb_boff  = fb_lvl < 12'h12c;
    flags.fb_leave = fb_lvl > 12'h1c2;
    flags.cs_bpk   = gate_on && ramp_q >= bpk_at;
    flags.cs_pk    = gate_on && ramp_q >= 12'hfff;
    flags.cs_sw    = gate_on && misc[0];
    flags.zc_ovp   = !gate_on && misc[1];
    flags.vcc_off  = vcc_lvl < 12'h3d9;
    flags.vcc_on   = vcc_lvl >= 12'h708;
    flags.vcc_pd   = vcc_lvl < PD_LVL;
    flags.vcc_ov   = vcc_lvl > 12'h9c4;
    flags.otp      = misc[2];
    flags.vdc_up   = misc[3];
    flags.vdc_dn   = misc[4];
    flags.norm_on  = misc[5];
  end
endmodule : bmp_plant

// ### testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ENT = 50;
  localparam int OVL = 60;
  localparam int ZCB = 40;
  localparam int MON = 2000;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        gate_on, bias_en, startup_en, burst_ilim, soft_start, burst_mode, latched_off;
  logic [2:0]  valley_cnt;
  logic [11:0] fb_lvl = 12'h190, vcc_lvl = 12'h000, bpk_at = 12'hfff;
  logic [5:0]  misc = 6'h00;
  logic [31:0] d;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          n, hi, per, at;
  bmp_pkg::bmp_flags_s flags;

  always #2.5 aclk = ~aclk;

  bmp_ctrl #(.ENTER_CYC(ENT), .OVLD_CYC(OVL), .ZC_OVP_CYC(ZCB), .MAX_ON_CYC(MON)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .flags(flags), .gate_on(gate_on), .bias_en(bias_en),
    .startup_en(startup_en), .burst_ilim(burst_ilim), .soft_start(soft_start), .burst_mode(burst_mode),
    .latched_off(latched_off), .valley_cnt(valley_cnt),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  bmp_plant i_plant (.aclk(aclk), .gate_on(gate_on), .fb_lvl(fb_lvl), .vcc_lvl(vcc_lvl),
                     .bpk_at(bpk_at), .misc(misc), .flags(flags));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic tmo;
    error_cnt++;
    $display("mismatch at %0t: wait ran out", $time);
    tally_and_finish();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic chk_in(input int got, input int lo, input int hi_b, input string m);
    num_checks++;
    if (got < lo || got > hi_b) begin
      error_cnt++;
      $display("mismatch at %0t: %s %0d not in %0d..%0d", $time, m, got, lo, hi_b);
    end
  endtask : chk_in

  // Samples at the edge, so outputs are the values settled before it
  task automatic wt(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge aclk);
      k++;
    end
    if (s !== v) tmo();
  endtask : wt

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 50);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (s_axi_bvalid !== 1'b1) tmo();
    // Idle edge so the next call never re-drives a signal in this step
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 50);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (s_axi_rvalid !== 1'b1) tmo();
    @(posedge aclk);
  endtask : axi_rd

  task automatic chk_st(input logic [2:0] e);
    axi_rd(bmp_pkg::STAT_OFF);
    chk({29'h0, d[2:0]}, {29'h0, e}, "state");
  endtask : chk_st

  task automatic go_run;
    vcc_lvl <= 12'h708;
    wt(bias_en, 1'b1, 20);
  endtask : go_run

  task automatic go_charge(input logic [11:0] v);
    vcc_lvl <= v;
    wt(startup_en, 1'b1, 20);
  endtask : go_charge

  task automatic tend(input string s);
    $display("test %s done, mismatches so far %0d", s, error_cnt);
  endtask : tend

  // Burst on-time ends at the peak flag or at half the period, whichever first
  function automatic int exp_hi(input int a);
    return (a < bmp_pkg::BURST_ON_CYC) ? a : bmp_pkg::BURST_ON_CYC;
  endfunction : exp_hi

  task automatic pulse(output int h, output int p);
    wt(gate_on, 1'b1, 8000);
    h = 0;
    while (gate_on === 1'b1 && h < 8000) begin
      @(posedge aclk);
      h++;
    end
    p = h;
    while (gate_on !== 1'b1 && p < 8000) begin
      @(posedge aclk);
      p++;
    end
  endtask : pulse

  task automatic cnt_until(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask : cnt_until

  initial begin
    void'($urandom(32'h2069));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({gate_on, bias_en, startup_en, burst_mode, latched_off, valley_cnt}, 8'h20, "reset outs");
    axi_rd(bmp_pkg::CTRL_OFF);
    chk(d, 32'h1, "ctrl reset");
    axi_rd(8'h40);
    chk(d, 32'h0, "unmapped read data");
    chk({30'h0, r}, {30'h0, bmp_pkg::RESP_SLVERR}, "unmapped read resp");
    axi_wr(8'h44, 32'h1);
    chk({30'h0, r}, {30'h0, bmp_pkg::RESP_SLVERR}, "unmapped write");
    axi_wr(bmp_pkg::STAT_OFF, 32'h0);
    chk({30'h0, r}, {30'h0, bmp_pkg::RESP_OKAY}, "status write");
    s_axi_wstrb <= 4'h0;
    axi_wr(bmp_pkg::CTRL_OFF, 32'h0);
    s_axi_wstrb <= 4'hf;
    axi_rd(bmp_pkg::CTRL_OFF);
    chk(d, 32'h1, "masked write");
    chk_st(bmp_pkg::ST_CHARGE);
    tend("registers");
    vcc_lvl <= 12'h708;
    wt(soft_start, 1'b1, 20);
    chk({bias_en, startup_en}, 2'b10, "run entry");
    chk_st(bmp_pkg::ST_RUN);
    fb_lvl <= 12'h064;
    axi_wr(bmp_pkg::CTRL_OFF, 32'h0);
    repeat (7) begin
      misc[3] <= 1'b1;
      @(posedge aclk);
      misc[3] <= 1'b0;
      @(posedge aclk);
    end
    repeat (ENT + 20) @(posedge aclk);
    chk({burst_mode, valley_cnt}, {1'b0, bmp_pkg::VDC_BURST}, "entry while disabled");
    axi_wr(bmp_pkg::CTRL_OFF, 32'h1);
    cnt_until(burst_mode, 1'b1, 200);
    chk_in(n, ENT - 2, ENT + 10, "entry blanking");
    chk({bias_en, burst_ilim}, 2'b01, "paused entry");
    fb_lvl <= 12'h190;
    wt(bias_en, 1'b1, 10);
    for (int k = 0; k < 5; k++) begin
      at = (k == 0) ? 4095 : 40 + $urandom % 1500;
      bpk_at <= at[11:0];
      pulse(hi, per);
      pulse(hi, per);
      chk_in(hi, exp_hi(at) - 2, exp_hi(at) + 5, "burst on time");
      chk_in(per, bmp_pkg::BURST_PER_CYC, bmp_pkg::BURST_PER_CYC, "burst period");
    end
    fb_lvl <= 12'h0fa;
    wt(bias_en, 1'b0, 10);
    n = 0;
    repeat (4000) begin
      @(posedge aclk);
      n += (gate_on !== 1'b0);
    end
    chk(n, 32'h0, "paused gate");
    tend("burst");
    fb_lvl <= 12'h1d6;
    wt(burst_mode, 1'b0, 10);
    chk({burst_ilim, valley_cnt}, {1'b0, bmp_pkg::VDC_LEAVE}, "leave burst");
    cnt_until(bias_en, 1'b0, 200);
    chk_in(n, OVL - 2, OVL + 6, "overload blanking");
    chk_st(bmp_pkg::ST_RESTART);
    fb_lvl <= 12'h190;
    go_charge(12'h384);
    go_run();
    repeat (2) begin
      misc[1] <= 1'b1;
      repeat (ZCB - 4) @(posedge aclk);
      misc[1] <= 1'b0;
      @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
    chk(latched_off, 1'b0, "broken over-voltage");
    misc[1] <= 1'b1;
    cnt_until(latched_off, 1'b1, 200);
    chk_in(n, ZCB, ZCB + 6, "over-voltage blanking");
    misc[1] <= 1'b0;
    go_charge(12'h384);
    vcc_lvl <= 12'h708;
    wt(startup_en, 1'b0, 20);
    chk(latched_off, 1'b1, "latch kept");
    vcc_lvl <= 12'h1f4;
    wt(latched_off, 1'b0, 20);
    go_run();
    tend("latch");
    misc[5] <= 1'b1;
    @(posedge aclk);
    misc[5] <= 1'b0;
    wt(gate_on, 1'b1, 20);
    cnt_until(gate_on, 1'b0, 4000);
    chk_in(n, MON, MON + 1, "max on-time");
    misc[5] <= 1'b1;
    misc[0] <= 1'b1;
    @(posedge aclk);
    misc[5] <= 1'b0;
    wt(latched_off, 1'b1, 80);
    misc[0] <= 1'b0;
    go_charge(12'h1f4);
    go_run();
    misc[2] <= 1'b1;
    wt(bias_en, 1'b0, 10);
    chk_st(bmp_pkg::ST_RESTART);
    misc[2] <= 1'b0;
    go_charge(12'h384);
    go_run();
    vcc_lvl <= 12'ha28;
    cnt_until(bias_en, 1'b0, 2200);
    chk_in(n, bmp_pkg::VCC_OV_CYC, bmp_pkg::VCC_OV_CYC + 8, "supply over-voltage");
    go_charge(12'h384);
    go_run();
    go_charge(12'h384);
    chk(gate_on, 1'b0, "under-voltage gate");
    chk_st(bmp_pkg::ST_CHARGE);
    tend("protection");
    tally_and_finish();
  end
endmodule : tb
